// ---- rtl/ufc_defs.svh ----
// Constants for the UART FIFO control block: field positions, reset values,
// trigger levels and flush timing.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef UFC_DEFS_SVH
`define UFC_DEFS_SVH

// ****************************************
// FIFO geometry
// ****************************************
`define UFC_DEPTH 7'h40
`define UFC_PTR_W 6
`define UFC_CNT_W 7

// ****************************************
// Control register fields and reset value
// ****************************************
`define UFC_CTRL_RESET 8'h00
`define UFC_BIT_ENABLE 0
`define UFC_BIT_RX_FLUSH 1
`define UFC_BIT_TX_FLUSH 2
`define UFC_RX_TRIG_HI 7
`define UFC_RX_TRIG_LO 6
`define UFC_TX_TRIG_HI 5
`define UFC_TX_TRIG_LO 4

// ****************************************
// Trigger levels (characters / spaces)
// ****************************************
`define UFC_RX_LVL_0 7'h08
`define UFC_RX_LVL_1 7'h10
`define UFC_RX_LVL_2 7'h38
`define UFC_RX_LVL_3 7'h3C
`define UFC_TX_LVL_0 7'h08
`define UFC_TX_LVL_1 7'h10
`define UFC_TX_LVL_2 7'h20
`define UFC_TX_LVL_3 7'h38

// ****************************************
// Flush timing in crystal clock periods, and in system clocks
// ****************************************
`define UFC_FLUSH_XTAL_PERIODS 2
`define UFC_FLUSH_CLKS (`UFC_FLUSH_XTAL_PERIODS)

`endif

// ---- rtl/ufc_pkg.sv ----
// Types shared by the UART FIFO control block.
// Assumes nothing beyond a SystemVerilog compiler.
package ufc_pkg;

    // Byte carried through the FIFOs
    typedef logic [7:0] ufc_byte_t;

    // Flush sequencer, Gray coded along idle -> clear1 -> clear2
    typedef enum logic [1:0] {
        UFC_IDLE = 2'h0,
        UFC_CLR1 = 2'h1,
        UFC_CLR2 = 2'h3
    } ufc_flush_t;

endpackage

// ---- rtl/ufc_mem.sv ----
// Small dual-port byte memory used as FIFO storage.
// Assumes one clock; read data come out of a register one cycle after re.
`timescale 1ns/1ps
`include "ufc_defs.svh"

module ufc_mem (
    // Clock
    input wire logic clk,
    // Write port
    input wire logic we,
    input wire logic [`UFC_PTR_W-1:0] waddr,
    input wire ufc_pkg::ufc_byte_t wdata,
    // Read port
    input wire logic re,
    input wire logic [`UFC_PTR_W-1:0] raddr,
    output ufc_pkg::ufc_byte_t rdata
);
    import ufc_pkg::*;

    ufc_byte_t store [64];
    ufc_byte_t next_rdata;

    // Read data selection
    always_comb begin
        next_rdata = re ? store[raddr] : rdata;
    end

    // Storage and registered read
    always_ff @(posedge clk) begin
        if (we) begin
            store[waddr] <= wdata;
        end
        rdata <= next_rdata;
    end

endmodule // ufc_mem

// ---- rtl/ufc_top.sv ----
// FIFO control for one UART: control register, two 64-byte FIFOs, flush and
// trigger logic. Assumes the host keeps its own flush wait before data access.
// Summary of operation
// - The FIFO control register is write-only and sets enable, flushes and both trigger thresholds.
// - Bits 7:6 choose the receive threshold of 8, 16, 56 or 60 characters.
// - Bits 5:4 choose the transmit threshold of 8, 16, 32 or 56 free spaces.
// - The transmit threshold field changes and takes effect only while enhanced functions are enabled.
// - Writing 1 to bit 2 empties the transmit FIFO and its count, leaving the shifter alone, then self-clears.
// - Writing 1 to bit 1 empties the receive FIFO and its count, leaving the shifter alone, then self-clears.
// - Bit 0 enables both FIFOs when 1 and disables both when 0, disabled after reset.
// - A flush lasts at least two crystal clock cycles.
// - With the FIFOs disabled, received characters are still kept in the first receive location.
`timescale 1ns/1ps
`include "ufc_defs.svh"

module ufc_top (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RESET,
    // Control register write port
    input wire logic CTRL_WR,
    input wire ufc_pkg::ufc_byte_t CTRL_DATA,
    input wire logic ENH_FUNC_EN,
    output ufc_pkg::ufc_byte_t FIFO_CTRL,
    // Receive side: shifter pushes, host pops
    input wire logic RX_PUSH,
    input wire ufc_pkg::ufc_byte_t RX_IN_DATA,
    input wire logic RX_POP,
    output ufc_pkg::ufc_byte_t RX_DATA,
    output logic RX_DATA_VALID,
    output logic [`UFC_CNT_W-1:0] RX_LEVEL,
    output logic RX_TRIG,
    // Transmit side: host pushes, shifter pulls
    input wire logic TX_WR,
    input wire ufc_pkg::ufc_byte_t TX_IN_DATA,
    input wire logic TX_PULL,
    output ufc_pkg::ufc_byte_t TX_DATA,
    output logic TX_DATA_VALID,
    output logic [`UFC_CNT_W-1:0] TX_LEVEL,
    output logic TX_TRIG
);
    import ufc_pkg::*;

    // ****************************************
    // Decoders
    // ****************************************

    // Receive threshold in characters
    function automatic logic [`UFC_CNT_W-1:0] rx_level(input logic [1:0] sel);
        case (sel)
            2'h0: rx_level = `UFC_RX_LVL_0;
            2'h1: rx_level = `UFC_RX_LVL_1;
            2'h2: rx_level = `UFC_RX_LVL_2;
            default: rx_level = `UFC_RX_LVL_3;
        endcase
    endfunction

    // Transmit threshold in free spaces
    function automatic logic [`UFC_CNT_W-1:0] tx_level(input logic [1:0] sel);
        case (sel)
            2'h0: tx_level = `UFC_TX_LVL_0;
            2'h1: tx_level = `UFC_TX_LVL_1;
            2'h2: tx_level = `UFC_TX_LVL_2;
            default: tx_level = `UFC_TX_LVL_3;
        endcase
    endfunction

    // ****************************************
    // Control register
    // ****************************************

    ufc_byte_t ctrl;
    ufc_byte_t next_ctrl;
    logic [1:0] flush_req;
    logic en_change;
    ufc_flush_t flush_st [2];

    assign en_change = CTRL_WR && (CTRL_DATA[`UFC_BIT_ENABLE] != ctrl[`UFC_BIT_ENABLE]);
    // Changing the enable empties both FIFOs so no stale pointer survives
    assign flush_req[0] = (CTRL_WR && CTRL_DATA[`UFC_BIT_RX_FLUSH]) || en_change;
    assign flush_req[1] = (CTRL_WR && CTRL_DATA[`UFC_BIT_TX_FLUSH]) || en_change;

    // Next control value; write-only, changed only by writes except the flush bits, which self-clear
    always_comb begin
        next_ctrl = ctrl;
        if (CTRL_WR) begin
            next_ctrl[`UFC_RX_TRIG_HI:`UFC_RX_TRIG_LO] = CTRL_DATA[`UFC_RX_TRIG_HI:`UFC_RX_TRIG_LO];
            next_ctrl[`UFC_BIT_ENABLE] = CTRL_DATA[`UFC_BIT_ENABLE];
            if (ENH_FUNC_EN) begin
                next_ctrl[`UFC_TX_TRIG_HI:`UFC_TX_TRIG_LO] = CTRL_DATA[`UFC_TX_TRIG_HI:`UFC_TX_TRIG_LO];
            end
        end
        // Flush bits self-clear at the end of clear2; a new request wins
        for (int i = 0; i < 2; i++) begin
            if (flush_req[i]) begin
                next_ctrl[`UFC_BIT_RX_FLUSH + i] = 1'b1;
            end else if (flush_st[i] == UFC_CLR2) begin
                next_ctrl[`UFC_BIT_RX_FLUSH + i] = 1'b0;
            end
        end
        next_ctrl[3] = 1'b0;
    end

    // Control register flops, FIFOs disabled after reset
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            ctrl <= `UFC_CTRL_RESET;
        end else begin
            ctrl <= next_ctrl;
        end
    end

    assign FIFO_CTRL = ctrl;

    // ****************************************
    // FIFO channels: 0 = receive, 1 = transmit
    // ****************************************

    logic push [2];
    logic pop [2];
    ufc_byte_t din [2];
    ufc_byte_t dout [2];
    logic [`UFC_PTR_W-1:0] wptr [2];
    logic [`UFC_PTR_W-1:0] rptr [2];
    logic [`UFC_CNT_W-1:0] cnt [2];
    logic vld [2];
    logic trig [2];
    logic mem_we [2];
    logic mem_re [2];
    logic [1:0] tx_sel;

    assign push[0] = RX_PUSH;
    assign pop[0] = RX_POP;
    assign din[0] = RX_IN_DATA;
    assign push[1] = TX_WR;
    assign pop[1] = TX_PULL;
    assign din[1] = TX_IN_DATA;
    // Transmit threshold only acts while enhanced functions are on
    assign tx_sel = ENH_FUNC_EN ? next_ctrl[`UFC_TX_TRIG_HI:`UFC_TX_TRIG_LO] : 2'h0;

    for (genvar g = 0; g < 2; g++) begin : g_chan
        ufc_flush_t next_st;
        logic [`UFC_PTR_W-1:0] next_wptr;
        logic [`UFC_PTR_W-1:0] next_rptr;
        logic [`UFC_CNT_W-1:0] next_cnt;
        logic [`UFC_CNT_W-1:0] cap;
        logic next_vld;
        logic next_trig;
        logic wr_ok;
        logic rd_ok;
        logic run;

        // Disabled FIFOs hold one byte in location zero
        assign cap = ctrl[`UFC_BIT_ENABLE] ? `UFC_DEPTH : 7'h01;
        assign run = (flush_st[g] == UFC_IDLE) && !flush_req[g];
        // Disabled receiver overwrites its holding byte rather than drop it
        assign wr_ok = push[g] && ((cnt[g] < cap) || (g == 0 && !ctrl[`UFC_BIT_ENABLE]));
        assign rd_ok = pop[g] && (cnt[g] != 7'h00);
        // Data ports are ignored while a flush runs
        assign mem_we[g] = run && wr_ok;
        assign mem_re[g] = run && rd_ok;

        // Flush sequencer and FIFO pointers
        always_comb begin
            next_st = flush_st[g];
            next_wptr = wptr[g];
            next_rptr = rptr[g];
            next_cnt = cnt[g];
            next_vld = 1'b0;
            if (flush_req[g]) begin
                next_st = UFC_CLR1;
            end else begin
                case (flush_st[g])
                    UFC_IDLE: next_st = UFC_IDLE;
                    UFC_CLR1: next_st = UFC_CLR2;
                    UFC_CLR2: next_st = UFC_IDLE;
                    default: next_st = UFC_IDLE;
                endcase
            end
            if (!run) begin
                // Empty storage and level; shifters are outside and untouched
                next_wptr = '0;
                next_rptr = '0;
                next_cnt = 7'h00;
            end else begin
                if (wr_ok && ctrl[`UFC_BIT_ENABLE]) begin
                    next_wptr = wptr[g] + 6'h01;
                end
                if (rd_ok && ctrl[`UFC_BIT_ENABLE]) begin
                    next_rptr = rptr[g] + 6'h01;
                end
                next_vld = rd_ok;
                if (wr_ok && !rd_ok && cnt[g] < cap) begin
                    next_cnt = cnt[g] + 7'h01;
                end else if (rd_ok && !wr_ok) begin
                    next_cnt = cnt[g] - 7'h01;
                end
            end
            if (g == 0) begin
                next_trig = next_cnt >= rx_level(next_ctrl[`UFC_RX_TRIG_HI:`UFC_RX_TRIG_LO]);
            end else begin
                next_trig = (`UFC_DEPTH - next_cnt) >= tx_level(tx_sel);
            end
        end

        // Channel flops
        always_ff @(posedge SYS_CLK) begin
            if (RESET) begin
                flush_st[g] <= UFC_IDLE;
                wptr[g] <= '0;
                rptr[g] <= '0;
                cnt[g] <= 7'h00;
                vld[g] <= 1'b0;
                trig[g] <= 1'b0;
            end else begin
                flush_st[g] <= next_st;
                wptr[g] <= next_wptr;
                rptr[g] <= next_rptr;
                cnt[g] <= next_cnt;
                vld[g] <= next_vld;
                trig[g] <= next_trig;
            end
        end

        // Storage for this channel
        ufc_mem u_mem (
            .clk(SYS_CLK),
            .we(mem_we[g]),
            .waddr(wptr[g]),
            .wdata(din[g]),
            .re(mem_re[g]),
            .raddr(rptr[g]),
            .rdata(dout[g])
        );
    end

    // Output mapping, all from flops
    assign RX_DATA = dout[0];
    assign RX_DATA_VALID = vld[0];
    assign RX_LEVEL = cnt[0];
    assign RX_TRIG = trig[0];
    assign TX_DATA = dout[1];
    assign TX_DATA_VALID = vld[1];
    assign TX_LEVEL = cnt[1];
    assign TX_TRIG = trig[1];

    // ****************************************
    // Checks
    // ****************************************

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RESET);

    ctl_write_only_a: assert property (
        !CTRL_WR |=> $stable(FIFO_CTRL[7:4]) && $stable(FIFO_CTRL[0]))
        else $error("control changed without a write");
    rx_top_level_a: assert property (
        (FIFO_CTRL[7:6] == 2'h3 && RX_LEVEL == 7'h3B) |-> !RX_TRIG)
        else $error("receive trigger below 60 characters");
    tx_space_32_a: assert property (
        (ENH_FUNC_EN && FIFO_CTRL[5:4] == 2'h2 && $stable(ENH_FUNC_EN) && TX_LEVEL == 7'h20) |-> TX_TRIG)
        else $error("transmit trigger missing at 32 spaces");
    tx_field_lock_a: assert property (
        (CTRL_WR && !ENH_FUNC_EN) |=> $stable(FIFO_CTRL[5:4]))
        else $error("transmit field changed while locked");
    tx_flush_empty_a: assert property (
        (CTRL_WR && CTRL_DATA[2]) |=> (TX_LEVEL == 7'h00 && FIFO_CTRL[2]))
        else $error("transmit flush did not empty");
    rx_flush_hold_a: assert property (
        $rose(FIFO_CTRL[1]) |-> (RX_LEVEL == 7'h00) [*2])
        else $error("receive flush did not hold empty");
    fifo_off_cap_a: assert property (
        !FIFO_CTRL[0] |-> (RX_LEVEL <= 7'h01 && TX_LEVEL <= 7'h01))
        else $error("disabled FIFO above one byte");
    flush_two_clk_a: assert property (
        $rose(FIFO_CTRL[2]) |=> FIFO_CTRL[2])
        else $error("flush shorter than two clocks");
    rx_hold_keep_a: assert property (
        (!FIFO_CTRL[0] && !CTRL_WR && flush_st[0] == UFC_IDLE && RX_PUSH && !RX_POP) |=> RX_LEVEL == 7'h01)
        else $error("disabled receiver lost its byte");
    rx_trig_flag_a: assert property (
        RX_TRIG == (RX_LEVEL >= rx_level(FIFO_CTRL[7:6])))
        else $error("receive trigger flag mismatch");

endmodule // ufc_top

// ---- verification/ufc_host_model.sv ----
// Host model: control writes, enhanced enable, transmit writes, receive reads.
// Assumes the bench calls its tasks and shares the system clock.
`timescale 1ns/1ps

module ufc_host_model (
    // Clock
    input wire logic clk,
    // Control register port
    output logic ctrl_wr,
    output ufc_pkg::ufc_byte_t ctrl_data,
    output logic enh_func_en,
    // Data ports
    output logic tx_wr,
    output ufc_pkg::ufc_byte_t tx_in_data,
    output logic rx_pop,
    input wire logic rx_data_valid,
    input wire ufc_pkg::ufc_byte_t rx_data
);
    import ufc_pkg::*;

    // Idle levels at time zero
    initial begin
        ctrl_wr = 1'b0;
        ctrl_data = 8'h5A;
        enh_func_en = 1'b0;
        tx_wr = 1'b0;
        tx_in_data = 8'hA5;
        rx_pop = 1'b0;
    end

    // One control write; never read back, the register is write-only
    task automatic write_ctrl(input ufc_byte_t d);
        @(posedge clk);
        ctrl_wr <= 1'b1;
        ctrl_data <= d;
        @(posedge clk);
        ctrl_wr <= 1'b0;
        ctrl_data <= ~d;
        #1;
    endtask

    // Keep off the data ports for two clocks after a flush
    task automatic flush_wait();
        repeat (2) @(posedge clk);
        #1;
    endtask

    // Enhanced enable level
    task automatic set_enh(input logic e);
        @(posedge clk);
        enh_func_en <= e;
        #1;
    endtask

    // One transmit byte; data line inverted once released
    task automatic write_tx(input ufc_byte_t d);
        @(posedge clk);
        tx_wr <= 1'b1;
        tx_in_data <= d;
        @(posedge clk);
        tx_wr <= 1'b0;
        tx_in_data <= ~d;
        #1;
    endtask

    // One receive read; answer is looked at in its single valid cycle
    task automatic read_rx(output logic v, output ufc_byte_t d);
        @(posedge clk);
        rx_pop <= 1'b1;
        @(posedge clk);
        rx_pop <= 1'b0;
        #1;
        v = rx_data_valid;
        d = rx_data;
    endtask
endmodule // ufc_host_model

// ---- verification/ufc_top_tb_top.sv ----
// Self-checking bench for the UART FIFO control block.
// Assumes the host model drives the host side; the bench plays both shifters.
`timescale 1ns/1ps
`include "ufc_defs.svh"

module ufc_top_tb_top;
    import ufc_pkg::*;

    logic SYS_CLK = 1'b0;
    logic RESET = 1'b1;
    logic CTRL_WR, ENH_FUNC_EN, RX_POP, TX_WR, RX_DATA_VALID, TX_DATA_VALID, RX_TRIG, TX_TRIG;
    logic RX_PUSH = 1'b0;
    logic TX_PULL = 1'b0;
    ufc_byte_t CTRL_DATA, FIFO_CTRL, RX_DATA, TX_IN_DATA, TX_DATA;
    ufc_byte_t RX_IN_DATA = 8'h00;
    logic [6:0] RX_LEVEL, TX_LEVEL;
    logic [6:0] rx_lvl [0:3] = '{`UFC_RX_LVL_0, `UFC_RX_LVL_1, `UFC_RX_LVL_2, `UFC_RX_LVL_3};
    logic [6:0] tx_lvl [0:3] = '{`UFC_TX_LVL_0, `UFC_TX_LVL_1, `UFC_TX_LVL_2, `UFC_TX_LVL_3};
    int n_fail = 0;
    int total_checks = 0;
    int cycles = 0;
    logic v;
    ufc_byte_t d;

    // 125 MHz clock
    always #4 SYS_CLK = ~SYS_CLK;

    ufc_top dut (.SYS_CLK(SYS_CLK), .RESET(RESET), .CTRL_WR(CTRL_WR), .CTRL_DATA(CTRL_DATA),
        .ENH_FUNC_EN(ENH_FUNC_EN), .FIFO_CTRL(FIFO_CTRL), .RX_PUSH(RX_PUSH), .RX_IN_DATA(RX_IN_DATA),
        .RX_POP(RX_POP), .RX_DATA(RX_DATA), .RX_DATA_VALID(RX_DATA_VALID), .RX_LEVEL(RX_LEVEL),
        .RX_TRIG(RX_TRIG), .TX_WR(TX_WR), .TX_IN_DATA(TX_IN_DATA), .TX_PULL(TX_PULL),
        .TX_DATA(TX_DATA), .TX_DATA_VALID(TX_DATA_VALID), .TX_LEVEL(TX_LEVEL), .TX_TRIG(TX_TRIG));

    ufc_host_model host (.clk(SYS_CLK), .ctrl_wr(CTRL_WR), .ctrl_data(CTRL_DATA), .enh_func_en(ENH_FUNC_EN),
        .tx_wr(TX_WR), .tx_in_data(TX_IN_DATA), .rx_pop(RX_POP), .rx_data_valid(RX_DATA_VALID),
        .rx_data(RX_DATA));

    // Verdict and end of run
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge SYS_CLK) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            n_fail = n_fail + 1;
            print_verdict();
        end
    end

    // Byte and flag comparisons
    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t flag %b expected %b", $time, got, exp);
        end
    endtask

    // Receive shifter side; data line inverted once released
    task automatic push_rx(input ufc_byte_t b);
        @(posedge SYS_CLK);
        RX_PUSH <= 1'b1;
        RX_IN_DATA <= b;
        @(posedge SYS_CLK);
        RX_PUSH <= 1'b0;
        RX_IN_DATA <= ~b;
        #1;
    endtask
    // Transmit shifter side
    task automatic pull_tx(output logic pv, output ufc_byte_t pd);
        @(posedge SYS_CLK);
        TX_PULL <= 1'b1;
        @(posedge SYS_CLK);
        TX_PULL <= 1'b0;
        #1;
        pv = TX_DATA_VALID;
        pd = TX_DATA;
    endtask
    // Flush write, bit seen set, then cleared after the wait
    task automatic flush(input ufc_byte_t c, input int b, input ufc_byte_t after);
        host.write_ctrl(c);
        chk_bit(FIFO_CTRL[b], 1'b1);
        host.flush_wait();
        chk_val(FIFO_CTRL, after);
    endtask

    // Reset state
    task automatic t_reset();
        chk_val(FIFO_CTRL, 8'h00);
        chk_val({1'b0, RX_LEVEL}, 8'h00);
        chk_bit(RX_TRIG, 1'b0);
        chk_bit(TX_TRIG, 1'b1);
        $display("test reset done");
    endtask

    // Every receive threshold code, edge of each level
    task automatic t_rx_trig();
        for (int i = 0; i < 4; i++) begin
            flush({i[1:0], 6'h03}, 1, {i[1:0], 6'h01});
            chk_val({1'b0, RX_LEVEL}, 8'h00);
            for (int j = 1; j < rx_lvl[i]; j++) push_rx(j[7:0]);
            chk_bit(RX_TRIG, 1'b0);
            push_rx(8'hEE);
            chk_bit(RX_TRIG, 1'b1);
        end
        $display("test rx trigger done");
    endtask

    // Transmit field gated by enhanced enable, then every code
    task automatic t_tx_trig();
        flush(8'h35, 2, 8'h01);
        host.set_enh(1'b1);
        for (int i = 0; i < 4; i++) begin
            flush({2'b00, i[1:0], 4'h5}, 2, {2'b00, i[1:0], 4'h1});
            chk_val({1'b0, TX_LEVEL}, 8'h00);
            for (int j = 0; j < 64 - tx_lvl[i]; j++) host.write_tx(j[7:0]);
            chk_bit(TX_TRIG, 1'b1);
            host.write_tx(8'h77);
            chk_bit(TX_TRIG, 1'b0);
        end
        // Field 11 kept but not acting: 55 spaces meet the 8-space default
        host.set_enh(1'b0);
        @(posedge SYS_CLK);
        #1;
        chk_bit(TX_TRIG, 1'b1);
        chk_val(FIFO_CTRL, 8'h31);
        host.set_enh(1'b1);
        @(posedge SYS_CLK);
        #1;
        chk_bit(TX_TRIG, 1'b0);
        $display("test tx trigger done");
    endtask

    // Data order through both FIFOs, flush with data held
    task automatic t_data();
        flush(8'h35, 2, 8'h31);
        host.write_tx(8'hA1);
        host.write_tx(8'hB2);
        pull_tx(v, d);
        chk_val(d, 8'hA1);
        pull_tx(v, d);
        chk_val(d, 8'hB2);
        flush(8'h33, 1, 8'h31);
        push_rx(8'h3C);
        push_rx(8'h5A);
        host.read_rx(v, d);
        chk_bit(v, 1'b1);
        chk_val(d, 8'h3C);
        host.read_rx(v, d);
        chk_val(d, 8'h5A);
        repeat (3) host.write_tx(8'h66);
        chk_val({1'b0, TX_LEVEL}, 8'h03);
        flush(8'h35, 2, 8'h31);
        chk_val({1'b0, TX_LEVEL}, 8'h00);
        pull_tx(v, d);
        chk_bit(v, 1'b0);
        $display("test data done");
    endtask

    // FIFOs off: single receive holding byte
    task automatic t_disabled();
        flush(8'h30, 1, 8'h30);
        push_rx(8'h11);
        push_rx(8'h22);
        chk_val({1'b0, RX_LEVEL}, 8'h01);
        host.read_rx(v, d);
        chk_bit(v, 1'b1);
        chk_val(d, 8'h22);
        $display("test disabled done");
    endtask

    // Main sequence
    initial begin
        repeat (6) @(posedge SYS_CLK);
        RESET <= 1'b0;
        @(posedge SYS_CLK);
        #1;
        t_reset();
        t_rx_trig();
        t_tx_trig();
        t_data();
        t_disabled();
        print_verdict();
    end
endmodule // ufc_top_tb_top
